// ==== hw/asp_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module asp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } asp_fifo_state_type;

    asp_fifo_state_type q;
    asp_fifo_state_type d;
    logic push;
    logic pop;

    assign in_ready_out = (q.cnt != (AW+1)'(DEPTH));
    assign out_valid_out = (q.cnt != '0);
    assign out_data_out = q.mem[q.rp];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data_in;
            d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
        end
        if (push && !pop) begin
            d.cnt = q.cnt + 1'b1;
        end else if (pop && !push) begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// ==== hw/asp_pkg.sv ====
// Shared constants and state types for the converter serial port
package asp_pkg;

    localparam int CTRL_W = 8;
    localparam int RES_W = 12;
    localparam int FIFO_DEPTH = 4;
    localparam int CNT_W = 5;

    // Frame positions, counted in serial clock rising edges after the start bit
    localparam logic [CNT_W-1:0] CNT_START = 5'h01;
    localparam logic [CNT_W-1:0] CNT_TRACK = 5'h05;
    localparam logic [CNT_W-1:0] CNT_CTRL_LAST = 5'h07;
    localparam logic [CNT_W-1:0] CNT_HOLD = 5'h08;
    localparam logic [CNT_W-1:0] CNT_STROBE = 5'h08;
    localparam logic [CNT_W-1:0] CNT_MSB = 5'h09;
    localparam logic [CNT_W-1:0] CNT_LSB = 5'h14;
    localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
    localparam logic [RES_W-1:0] RES_RST = 12'h000;
    localparam logic [CNT_W-1:0] CNT_RST = 5'h00;

    // Core clock side
    typedef struct packed {
        logic pwr_s1;
        logic pwr_s2;
        logic sleep;
        logic ct_s1;
        logic ct_s2;
        logic ct_s3;
        logic ak_s1;
        logic ak_s2;
        logic pend_v;
        logic [CTRL_W-1:0] pend;
        logic cmd_v;
        logic [CTRL_W-1:0] cmd;
        logic ovr;
        logic req;
        logic [RES_W-1:0] word;
        logic s_rdy;
    } asp_core_type;

    // Link side, cleared whenever chip select is high
    typedef struct packed {
        logic started;
        logic [CNT_W-1:0] cnt;
        logic [CTRL_W-1:0] sh;
        logic [RES_W-1:0] res;
        logic dout;
        logic strb;
        logic oe;
    } asp_frame_type;

    // Link side, kept across frames
    typedef struct packed {
        logic rq_s1;
        logic rq_s2;
        logic ack_tgl;
        logic [RES_W-1:0] held;
        logic sl_s1;
        logic sl_s2;
        logic ctrl_tgl;
        logic [CTRL_W-1:0] ctrl_byte;
    } asp_keep_type;

endpackage

// ==== hw/asp_serial_port.sv ====
// Serial port of a four-channel converter: link logic on the serial clock, core on ref clock
`timescale 1ns/1ps

// Operation
// - Capture input data on serial clock rise
// - Ignore input data while chip select high
// - Update output data on serial clock rise
// - Outputs high impedance while chip select high
// - Strobe high one period before MSB
// - Conversion timing paced by serial clock only
// - Shutdown input low minimises device activity
// - Skip leading zeros; first one starts byte
// - Track after fifth bit, hold after eighth
module asp_serial_port
    import asp_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic din_in,
    output logic dout_out,
    output logic dout_oe_out,
    output logic frame_strobe_out,
    output logic frame_strobe_oe_out,
    output logic track_out,
    input wire logic power_off_n_in,
    output logic shutdown_out,
    input wire logic [RES_W-1:0] sample_in,
    input wire logic sample_valid_in,
    output logic sample_ready_out,
    output logic [CTRL_W-1:0] cmd_data_out,
    output logic cmd_valid_out,
    input wire logic cmd_ready_in,
    output logic overrun_out,
    input wire logic overrun_clr_in
);
    asp_core_type c_q;
    asp_core_type c_d;
    asp_frame_type f_q;
    asp_frame_type f_d;
    asp_keep_type k_q;
    asp_keep_type k_d;
    logic track_q;
    logic track_d;
    logic link_clr_n;
    logic ctrl_done;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [CTRL_W-1:0] fifo_out_data;
    logic ctrl_arrived;
    logic sample_take;
    logic ph_ctrl;
    logic ph_strobe;
    logic ph_result;
    logic ph_track_on;
    logic ph_track_off;
    logic ph_counting;

    // Chip select high clears the frame at once, so outputs float without waiting for a clock
    assign link_clr_n = rst_n_in & ~cs_n_in;

    // Link domain, frame part
    // Phase flags are decoded once from the edge count and shared by both link edges
    always_comb begin
        ph_ctrl = f_q.started && (f_q.cnt < CNT_HOLD);
        ph_strobe = f_q.started && (f_q.cnt == CNT_STROBE);
        ph_result = f_q.started && (f_q.cnt >= CNT_MSB) && (f_q.cnt <= CNT_LSB);
        ph_track_on = f_q.started && (f_q.cnt == CNT_TRACK);
        ph_track_off = f_q.started && (f_q.cnt == CNT_HOLD);
        ph_counting = f_q.started && (f_q.cnt != CNT_MAX);
        // Eighth control bit is being captured on this edge
        ctrl_done = f_q.started && (f_q.cnt == CNT_CTRL_LAST);
    end

    always_comb begin
        f_d = f_q;
        // A device in shutdown stays silent on the link
        f_d.oe = ~k_q.sl_s2;
        if (k_q.sl_s2) begin
            f_d.started = 1'b0;
            f_d.dout = 1'b0;
            f_d.strb = 1'b0;
        end else if (!f_q.started) begin
            // Leading zeros are dropped until the first one
            if (din_in) begin
                f_d.started = 1'b1;
                f_d.cnt = CNT_START;
                f_d.sh = {{(CTRL_W-1){1'b0}}, din_in};
            end
        end else begin
            if (ph_counting) begin
                f_d.cnt = f_q.cnt + 1'b1;
            end
            if (ph_ctrl) begin
                f_d.sh = {f_q.sh[CTRL_W-2:0], din_in};
            end
            // Strobe marks the period before the first result bit
            f_d.strb = ph_strobe;
            if (ph_strobe) begin
                f_d.res = k_q.held;
            end
            if (ph_result) begin
                f_d.dout = f_q.res[RES_W-1];
                f_d.res = {f_q.res[RES_W-2:0], 1'b0};
            end else begin
                f_d.dout = 1'b0;
            end
        end
    end

    // Only rising edges while selected reach this state
    always_ff @(posedge sclk_in or negedge link_clr_n) begin
        if (!link_clr_n) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end

    // Track and hold switch on falling edges
    always_comb begin
        track_d = track_q;
        // Shutdown in mid-track must not leave the switch closed
        if (k_q.sl_s2) begin
            track_d = 1'b0;
        end else if (ph_track_on) begin
            track_d = 1'b1;
        end else if (ph_track_off) begin
            track_d = 1'b0;
        end
    end

    always_ff @(negedge sclk_in or negedge link_clr_n) begin
        if (!link_clr_n) begin
            track_q <= 1'b0;
        end else begin
            track_q <= track_d;
        end
    end

    // Link domain, persistent part
    always_comb begin
        k_d = k_q;
        k_d.rq_s1 = c_q.req;
        k_d.rq_s2 = k_q.rq_s1;
        k_d.sl_s1 = c_q.sleep;
        k_d.sl_s2 = k_q.sl_s1;
        // Core holds its word steady until this acknowledge returns
        if (k_q.rq_s2 != k_q.ack_tgl) begin
            k_d.held = c_q.word;
            k_d.ack_tgl = k_q.rq_s2;
        end
        if (ctrl_done && !cs_n_in) begin
            k_d.ctrl_byte = {f_q.sh[CTRL_W-2:0], din_in};
            k_d.ctrl_tgl = ~k_q.ctrl_tgl;
        end
    end

    // The serial clock may stop between frames; the handshakes tolerate that
    always_ff @(posedge sclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            k_q <= '0;
        end else begin
            k_q <= k_d;
        end
    end

    // Core domain
    assign ctrl_arrived = c_q.ct_s2 ^ c_q.ct_s3;
    assign sample_take = c_q.s_rdy && sample_valid_in;
    assign fifo_out_ready = !c_q.cmd_v || cmd_ready_in;

    always_comb begin
        c_d = c_q;
        // Chain carries the off request, so its reset value is that of a powered pin
        c_d.pwr_s1 = ~power_off_n_in;
        c_d.pwr_s2 = c_q.pwr_s1;
        c_d.sleep = c_q.pwr_s2;
        c_d.ct_s1 = k_q.ctrl_tgl;
        c_d.ct_s2 = c_q.ct_s1;
        c_d.ct_s3 = c_q.ct_s2;
        c_d.ak_s1 = k_q.ack_tgl;
        c_d.ak_s2 = c_q.ak_s1;
        // Pending byte waits here while the FIFO is full
        if (c_q.pend_v && fifo_in_ready) begin
            c_d.pend_v = 1'b0;
        end
        if (overrun_clr_in) begin
            c_d.ovr = 1'b0;
        end
        if (ctrl_arrived) begin
            if (c_q.pend_v && !fifo_in_ready) begin
                c_d.ovr = 1'b1;
            end
            c_d.pend_v = 1'b1;
            c_d.pend = k_q.ctrl_byte;
        end
        if (fifo_out_ready) begin
            c_d.cmd_v = fifo_out_valid;
            if (fifo_out_valid) begin
                c_d.cmd = fifo_out_data;
            end
        end
        if (sample_take) begin
            c_d.word = sample_in;
            c_d.req = ~c_q.req;
        end
        c_d.s_rdy = !sample_take && (c_q.ak_s2 == c_q.req) && !c_q.sleep;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    asp_fifo #(
        .WIDTH(CTRL_W),
        .DEPTH(FIFO_DEPTH)
    ) asp_fifo_i (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(c_q.pend_v),
        .in_ready_out(fifo_in_ready),
        .in_data_in(c_q.pend),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_out_ready),
        .out_data_out(fifo_out_data)
    );

    assign dout_out = f_q.dout;
    assign dout_oe_out = f_q.oe;
    assign frame_strobe_out = f_q.strb;
    assign frame_strobe_oe_out = f_q.oe;
    assign track_out = track_q;
    assign shutdown_out = c_q.sleep;
    assign sample_ready_out = c_q.s_rdy;
    assign cmd_data_out = c_q.cmd;
    assign cmd_valid_out = c_q.cmd_v;
    assign overrun_out = c_q.ovr;
endmodule

// ==== test/asp_serial_port_monitor.sv ====
// Concurrent checks on the converter serial port pins
`timescale 1ns/1ps
module asp_serial_port_monitor
    import asp_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic dout_oe_out,
    input wire logic frame_strobe_out,
    input wire logic frame_strobe_oe_out,
    input wire logic track_out,
    input wire logic power_off_n_in,
    input wire logic shutdown_out,
    input wire logic sample_valid_in,
    input wire logic sample_ready_out,
    input wire logic [CTRL_W-1:0] cmd_data_out,
    input wire logic cmd_valid_out,
    input wire logic cmd_ready_in
);
    oe_off_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        cs_n_in |-> !dout_oe_out && !frame_strobe_oe_out) else $error("enable with cs high");
    frame_clear_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        cs_n_in |-> !track_out && !frame_strobe_out) else $error("frame state kept");
    // Link checks pause while deselected, since cs high clears that logic at once
    strobe_pulse_a: assert property (@(posedge sclk_in) disable iff (!rst_n_in || cs_n_in)
        $rose(frame_strobe_out) |=> !frame_strobe_out) else $error("strobe too long");
    track_hold_a: assert property (@(posedge sclk_in) disable iff (!rst_n_in || cs_n_in)
        $fell(track_out) |=> frame_strobe_out) else $error("strobe not after hold");
    track_span_a: assert property (@(posedge sclk_in) disable iff (!rst_n_in || cs_n_in)
        $rose(track_out) |-> track_out [*3] ##1 !track_out) else $error("track span wrong");
    sleep_sync_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        !power_off_n_in [*3] |=> shutdown_out) else $error("shutdown late");
    sleep_idle_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        shutdown_out [*2] |-> !sample_ready_out) else $error("ready while shut down");
    cmd_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        cmd_valid_out && !cmd_ready_in |=> cmd_valid_out && $stable(cmd_data_out))
        else $error("command dropped");
    sample_take_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        sample_valid_in && sample_ready_out |=> !sample_ready_out) else $error("ready held");
endmodule

bind asp_serial_port asp_serial_port_monitor asp_serial_port_monitor_i (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in),
    .dout_oe_out(dout_oe_out), .frame_strobe_out(frame_strobe_out),
    .frame_strobe_oe_out(frame_strobe_oe_out), .track_out(track_out),
    .power_off_n_in(power_off_n_in), .shutdown_out(shutdown_out),
    .sample_valid_in(sample_valid_in), .sample_ready_out(sample_ready_out),
    .cmd_data_out(cmd_data_out), .cmd_valid_out(cmd_valid_out), .cmd_ready_in(cmd_ready_in));

// ==== test/asp_serial_port_tb.sv ====
// Self-checking bench for the converter serial port
`timescale 1ns/1ps
module asp_serial_port_tb;
    import asp_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic power_off_n_in = 1'b1;
    logic sample_valid_in = 1'b0;
    logic cmd_ready_in = 1'b0;
    logic overrun_clr_in = 1'b0;
    logic [RES_W-1:0] sample_in = 12'h000;
    logic sclk_in, cs_n_in, din_in, dout_out, dout_oe_out, frame_strobe_out, frame_strobe_oe_out;
    logic track_out, shutdown_out, sample_ready_out, cmd_valid_out, overrun_out;
    logic [CTRL_W-1:0] cmd_data_out;
    int errors = 0;
    int n_compared = 0;

    asp_serial_port asp_serial_port_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .sclk_in(sclk_in), .cs_n_in(cs_n_in), .din_in(din_in), .dout_out(dout_out),
        .dout_oe_out(dout_oe_out), .frame_strobe_out(frame_strobe_out),
        .frame_strobe_oe_out(frame_strobe_oe_out), .track_out(track_out),
        .power_off_n_in(power_off_n_in), .shutdown_out(shutdown_out), .sample_in(sample_in),
        .sample_valid_in(sample_valid_in), .sample_ready_out(sample_ready_out),
        .cmd_data_out(cmd_data_out), .cmd_valid_out(cmd_valid_out), .cmd_ready_in(cmd_ready_in),
        .overrun_out(overrun_out), .overrun_clr_in(overrun_clr_in));
    asp_spi_master asp_spi_master_i (.sclk_out(sclk_in), .cs_n_out(cs_n_in), .din_out(din_in),
        .dout_in(dout_out), .dout_oe_in(dout_oe_out), .strobe_in(frame_strobe_out));

    initial begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask

    task automatic take_cmd(input logic [7:0] exp);
        int i;
        for (i = 0; i < 100 && cmd_valid_out !== 1'b1; i++) tick(1);
        check(cmd_valid_out, 1'b1);
        check(cmd_data_out, exp);
        cmd_ready_in = 1'b1;
        tick(1);
        cmd_ready_in = 1'b0;
        // Let an edge pass with ready low before the next take raises it again
        tick(1);
    endtask

    task automatic t_conv;
        for (int i = 0; i < 20 && sample_ready_out !== 1'b1; i++) tick(1);
        sample_in = 12'ha5c;
        sample_valid_in = 1'b1;
        tick(1);
        sample_valid_in = 1'b0;
        // Sample reaches the link on the third edge of the first frame, as the link only clocks during frames
        asp_spi_master_i.frame({8'h8f, 16'h0000}, 24);
        take_cmd(8'h8f);
        asp_spi_master_i.frame({3'h0, 8'hc3, 13'h0000}, 24);
        take_cmd(8'hc3);
        check(asp_spi_master_i.rx_strb[13:11], 3'h2);
        check(asp_spi_master_i.rx_data[11:0], 12'ha5c);
        check(asp_spi_master_i.oe_seen, 1'b1);
    endtask

    task automatic t_abort;
        asp_spi_master_i.frame({8'h9f, 16'h0000}, 5);
        tick(30);
        check(cmd_valid_out, 1'b0);
        asp_spi_master_i.frame({1'h0, 8'hb6, 15'h0000}, 24);
        take_cmd(8'hb6);
    endtask

    task automatic t_sleep;
        power_off_n_in = 1'b0;
        tick(6);
        check(shutdown_out, 1'b1);
        check(sample_ready_out, 1'b0);
        asp_spi_master_i.frame({4'h0, 8'hff, 12'h000}, 24);
        tick(30);
        check(cmd_valid_out, 1'b0);
        power_off_n_in = 1'b1;
        tick(6);
        check(shutdown_out, 1'b0);
    endtask

    task automatic t_over;
        // Seven bytes against six places: the last replaces the stuck one
        for (int i = 0; i < 7; i++) asp_spi_master_i.frame({3'h0, 8'h80 + i[7:0], 13'h0000}, 24);
        tick(10);
        check(overrun_out, 1'b1);
        for (int i = 0; i < 5; i++) take_cmd(8'h80 + i[7:0]);
        take_cmd(8'h86);
        overrun_clr_in = 1'b1;
        tick(1);
        overrun_clr_in = 1'b0;
        check(overrun_out, 1'b0);
    endtask

    task automatic print_verdict;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        print_verdict;
    end

    initial begin
        tick(8);
        rst_n_in = 1'b1;
        tick(2);
        t_conv;
        t_abort;
        t_sleep;
        t_over;
        print_verdict;
    end
endmodule

// ==== test/asp_spi_master.sv ====
// Serial bus master that clocks frames into the converter port
`timescale 1ns/1ps
module asp_spi_master (
    output logic sclk_out,
    output logic cs_n_out,
    output logic din_out,
    input wire logic dout_in,
    input wire logic dout_oe_in,
    input wire logic strobe_in
);
    logic [31:0] rx_data;
    logic [31:0] rx_strb;
    logic oe_seen;
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        din_out = 1'b0;
    end
    // Clock idles low, data moves on the fall and is taken on the rise
    task automatic frame(input logic [23:0] bits, input int nclk);
        oe_seen = 1'b0;
        din_out = bits[23];
        cs_n_out = 1'b0;
        #40;
        for (int k = 0; k < nclk; k++) begin
            sclk_out = 1'b1;
            #60; // High share of 48 percent
            rx_data = {rx_data[30:0], dout_in};
            rx_strb = {rx_strb[30:0], strobe_in};
            oe_seen = oe_seen | dout_oe_in;
            sclk_out = 1'b0;
            bits = {bits[22:0], 1'b0};
            din_out = bits[23];
            #65;
        end
        cs_n_out = 1'b1;
        // Released line must not look like a held bit
        din_out = ~din_out;
        #150;
    endtask
endmodule
